//--- core/dnfps_pkg.sv
package dnfps_pkg;

  // Width codes driven on the width pins
  localparam logic [1:0] WIDTH_LONG = 2'h0;
  localparam logic [1:0] WIDTH_BYTE = 2'h1;
  localparam logic [1:0] WIDTH_WORD = 2'h2;
  localparam logic [1:0] WIDTH_LINE = 2'h3;

  // Port size codes, same shape as the width codes
  localparam logic [1:0] PORT_32 = 2'h0;
  localparam logic [1:0] PORT_8  = 2'h1;
  localparam logic [1:0] PORT_16 = 2'h2;

  // Column strobe lanes per port size
  localparam logic [3:0] LANES_32 = 4'hf;
  localparam logic [3:0] LANES_16 = 4'h3;
  localparam logic [3:0] LANES_8  = 4'h1;

  // Address field on the multiplexed pins
  localparam int ROW_LSB = 9;
  localparam int ROW_MSB = 27;
  localparam int PIN_W   = ROW_MSB - ROW_LSB + 1;

  // Page compare mask for the smallest page, shifted by page size
  localparam logic [31:0] PAGE_MASK_BASE = 32'hffff_fe00;

  // Timing
  localparam int CLK_NS      = 100;
  localparam int RAS_PRE_NS  = 150;
  // Low-phase reassertion supplies the last half clock of precharge
  localparam int RAS_PRE_CYC = (RAS_PRE_NS + CLK_NS - 1) / CLK_NS - 1;
  localparam int MIN_GAP_CYC = 2;

  typedef struct packed {
    logic [31:0] addr;
    logic        read;
    logic [1:0]  width;
    logic        bank;
  } dnfps_req_s;

  typedef struct packed {
    logic       fastPage;
    logic [1:0] portSize;
    logic [1:0] bankPageSize;
    logic [3:0] rasPreExtra;
    logic [3:0] casExtra;
  } dnfps_cfg_s;

  typedef struct packed {
    logic [PIN_W-1:0] addr;
    logic             transferStartN;
    logic             dramRwIndicatorN;
    logic [1:0]       xferWidthCode;
  } dnfps_bus_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ROW, ST_COL, ST_ACK, ST_PRE
  } dnfps_state_e;

endpackage

//--- core/dnfps_core.sv
// Notes on behaviour
// - First high phase: row address, read/write, width code, start low.
// - Row strobe asserts in the low phase after start.
// - Second high phase: start negates, column address replaces row.
// - Next low phase: column strobes for active lanes; 8-bit reads top.
// - Third high phase: acknowledge asserts; data taken at next edge.
// - Fourth high phase: capture read data, drop ack and column strobe; row strobe too in normal mode.
// - Normal mode: next core transfer starts no earlier than sixth phase.
// - Wide operands split into port-width beats; start asserted once.
// - Each normal-mode secondary beat waits for the programmed row precharge.
// - Normal burst minimum: 3 clocks first beat, 4 clocks later beats.
// - 16-bit writes: data on upper lanes with column, then strobes 1:0.
// - Between normal beats: next row and data, row strobe held off.
// - Final write beat done: all data lines released.
// - Fast page: latch row of first transfer, classify hit or miss.
// - Page compare covers bits down to 9, 10, 11 or 12 per page size.
// - Open page keeps row strobe; hits drive column and pulse strobe.
// - Close page on miss, other bank, lost mastership, refresh pending.
// - Closed bank blocked until row precharge time is met.
// - Fast page bursts of 2 to 16 segments, one ack per segment.
// - Fast page burst minimum: 3 clocks first beat (2 on a page hit), 2 clocks later.
// - Width code 0 long, 1 byte, 2 word; indicator high for reads.
// - Reads and writes share strobe and address timing.
// - Other bank waits only on its own row precharge count, not the closed bank's.
`timescale 1ns/1ps
module dnfps_core (
  input  wire logic                clock,
  input  wire logic                clockEn,
  input  wire logic                nrst,
  input  wire dnfps_pkg::dnfps_req_s req,
  input  wire logic                reqValid,
  output logic                     reqReady,
  input  wire logic [31:0]         wrData,
  input  wire dnfps_pkg::dnfps_cfg_s cfg,
  input  wire logic                refreshPending,
  input  wire logic                busMasterLost,
  output logic                     internalTransferAck,
  output logic [31:0]              rdData,
  output logic                     rdValid,
  output dnfps_pkg::dnfps_bus_s    busOut,
  output logic [1:0]               rowStrobeN,
  output logic [3:0]               colStrobeN,
  input  wire logic [31:0]         dataIn,
  output logic [31:0]              dataOut,
  output logic                     dataOe,
  output logic                     pageOpen
);

  dnfps_pkg::dnfps_state_e st_q, st_d;
  dnfps_pkg::dnfps_bus_s   bus_q, bus_d;
  dnfps_pkg::dnfps_req_s   cur_q, cur_d;
  logic        rasReq_q, rasReq_d;
  logic        casReq_q, casReq_d;
  logic        casTag_q, casTag_d;
  logic        ack_q, ack_d;
  logic        rdValid_q, rdValid_d;
  logic [31:0] rdData_q, rdData_d;
  logic [31:0] dOut_q, dOut_d;
  logic        dOe_q, dOe_d;
  logic [4:0]  beats_q, beats_d;
  logic [4:0]  wait_q, wait_d;
  logic [4:0]  gap_q, gap_d;
  logic [4:0]  bankPre_q [2];
  logic [4:0]  bankPre_d [2];
  logic        open_q, open_d;
  logic [31:0] openRow_q, openRow_d;
  logic        rasLow_q, casLow_q, casTagN_q;

  logic [1:0]  portShift;
  logic [31:0] pageMask;
  logic [31:0] nextAddr;
  logic [4:0]  preLoad;
  logic        pageHit;
  logic        closeNeed;
  logic        canStart;
  logic        rasOn;
  logic        casOn;
  logic [3:0]  lanes;

  // Beats per operand for the bank port
  function automatic logic [4:0] beatCount(input logic [1:0] w,
                                           input logic [1:0] s);
    logic [4:0] bytes;
    logic [4:0] n;
    bytes = 5'h4;
    case (w)
      dnfps_pkg::WIDTH_BYTE: bytes = 5'h1;
      dnfps_pkg::WIDTH_WORD: bytes = 5'h2;
      dnfps_pkg::WIDTH_LINE: bytes = 5'h10;
      default:               bytes = 5'h4;
    endcase
    n = bytes >> s;
    beatCount = (n == 5'h0) ? 5'h1 : n;
  endfunction

  // Port size decode and page compare
  always_comb begin
    portShift = 2'h2;
    lanes     = dnfps_pkg::LANES_32;
    if (cfg.portSize == dnfps_pkg::PORT_8) begin
      portShift = 2'h0;
      lanes     = dnfps_pkg::LANES_8;
    end else if (cfg.portSize == dnfps_pkg::PORT_16) begin
      portShift = 2'h1;
      lanes     = dnfps_pkg::LANES_16;
    end
    pageMask = dnfps_pkg::PAGE_MASK_BASE << cfg.bankPageSize;
    nextAddr = cur_q.addr + (32'h1 << portShift);
    preLoad  = 5'(dnfps_pkg::RAS_PRE_CYC) + {1'b0, cfg.rasPreExtra};
    pageHit  = (((req.addr ^ openRow_q) & pageMask) == 32'h0)
               && (req.bank == cur_q.bank);
    closeNeed = open_q && (busMasterLost || refreshPending
                || (reqValid && !pageHit));
    // Gap after a transfer holds for page hits as well
    canStart = reqValid && !refreshPending && !busMasterLost
               && (gap_q <= 5'h1)
               && (open_q || (bankPre_q[req.bank] <= 5'h1));
    reqReady = (st_q == dnfps_pkg::ST_IDLE) && canStart && !closeNeed;
  end

  // Sequencer next state
  always_comb begin
    st_d      = st_q;
    bus_d     = bus_q;
    bus_d.transferStartN = 1'b1;
    cur_d     = cur_q;
    rasReq_d  = rasReq_q;
    casReq_d  = casReq_q;
    casTag_d  = casTag_q;
    ack_d     = 1'b0;
    rdValid_d = 1'b0;
    rdData_d  = rdData_q;
    dOut_d    = dOut_q;
    dOe_d     = dOe_q;
    beats_d   = beats_q;
    wait_d    = wait_q;
    gap_d     = (gap_q != 5'h0) ? gap_q - 5'h1 : gap_q;
    open_d    = open_q;
    openRow_d = openRow_q;
    for (int i = 0; i < 2; i++) begin
      bankPre_d[i] = (bankPre_q[i] != 5'h0) ? bankPre_q[i] - 5'h1
                                             : bankPre_q[i];
    end
    case (st_q)
      dnfps_pkg::ST_IDLE: begin
        if (closeNeed) begin
          rasReq_d = 1'b0;
          open_d   = 1'b0;
          bankPre_d[cur_q.bank] = preLoad;
        end else if (reqReady) begin
          cur_d   = req;
          beats_d = beatCount(req.width, portShift);
          bus_d.transferStartN   = 1'b0;
          bus_d.dramRwIndicatorN = req.read;
          bus_d.xferWidthCode    = req.width;
          if (open_q) begin
            st_d      = dnfps_pkg::ST_COL;
            bus_d.addr = dnfps_pkg::PIN_W'(req.addr >> portShift);
            casReq_d  = 1'b1;
            casTag_d  = ~casTag_q;
            wait_d    = {1'b0, cfg.casExtra};
            dOut_d    = wrData;
            dOe_d     = ~req.read;
          end else begin
            st_d       = dnfps_pkg::ST_ROW;
            bus_d.addr = req.addr[dnfps_pkg::ROW_MSB:dnfps_pkg::ROW_LSB];
            rasReq_d   = 1'b1;
          end
        end
      end
      dnfps_pkg::ST_ROW: begin
        st_d       = dnfps_pkg::ST_COL;
        bus_d.addr = dnfps_pkg::PIN_W'(cur_q.addr >> portShift);
        casReq_d   = 1'b1;
        casTag_d   = ~casTag_q;
        wait_d     = {1'b0, cfg.casExtra};
        if (!cur_q.read) begin
          dOut_d = wrData;
          dOe_d  = 1'b1;
        end
      end
      dnfps_pkg::ST_COL: begin
        if (wait_q != 5'h0) begin
          wait_d = wait_q - 5'h1;
        end else begin
          st_d  = dnfps_pkg::ST_ACK;
          ack_d = 1'b1;
        end
      end
      dnfps_pkg::ST_ACK: begin
        casReq_d = 1'b0;
        if (cur_q.read) begin
          rdData_d  = dataIn;
          rdValid_d = 1'b1;
        end
        if (beats_q > 5'h1) begin
          beats_d    = beats_q - 5'h1;
          cur_d.addr = nextAddr;
          dOut_d     = wrData;
          if (cfg.fastPage) begin
            st_d       = dnfps_pkg::ST_COL;
            bus_d.addr = dnfps_pkg::PIN_W'(nextAddr >> portShift);
            casReq_d   = 1'b1;
            casTag_d   = ~casTag_q;
            wait_d     = {1'b0, cfg.casExtra};
          end else begin
            st_d       = dnfps_pkg::ST_PRE;
            rasReq_d   = 1'b0;
            bus_d.addr = nextAddr[dnfps_pkg::ROW_MSB:dnfps_pkg::ROW_LSB];
            wait_d     = preLoad;
          end
        end else begin
          st_d  = dnfps_pkg::ST_IDLE;
          dOe_d = 1'b0;
          gap_d = 5'(dnfps_pkg::MIN_GAP_CYC);
          if (cfg.fastPage) begin
            open_d    = 1'b1;
            openRow_d = cur_q.addr;
          end else begin
            rasReq_d = 1'b0;
            bankPre_d[cur_q.bank] = preLoad;
          end
        end
      end
      dnfps_pkg::ST_PRE: begin
        if (wait_q <= 5'h1) begin
          st_d     = dnfps_pkg::ST_ROW;
          rasReq_d = 1'b1;
          wait_d   = 5'h0;
        end else begin
          wait_d = wait_q - 5'h1;
        end
      end
      default: st_d = dnfps_pkg::ST_IDLE;
    endcase
  end

  // Sequencer registers, rising edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q      <= dnfps_pkg::ST_IDLE;
      bus_q     <= '{addr: '0, transferStartN: 1'b1,
                     dramRwIndicatorN: 1'b1, xferWidthCode: 2'h0};
      cur_q     <= '0;
      rasReq_q  <= 1'b0;
      casReq_q  <= 1'b0;
      casTag_q  <= 1'b0;
      ack_q     <= 1'b0;
      rdValid_q <= 1'b0;
      rdData_q  <= 32'h0;
      dOut_q    <= 32'h0;
      dOe_q     <= 1'b0;
      beats_q   <= 5'h0;
      wait_q    <= 5'h0;
      gap_q     <= 5'h0;
      open_q    <= 1'b0;
      openRow_q <= 32'h0;
      bankPre_q[0] <= 5'h0;
      bankPre_q[1] <= 5'h0;
    end else if (clockEn) begin
      st_q      <= st_d;
      bus_q     <= bus_d;
      cur_q     <= cur_d;
      rasReq_q  <= rasReq_d;
      casReq_q  <= casReq_d;
      casTag_q  <= casTag_d;
      ack_q     <= ack_d;
      rdValid_q <= rdValid_d;
      rdData_q  <= rdData_d;
      dOut_q    <= dOut_d;
      dOe_q     <= dOe_d;
      beats_q   <= beats_d;
      wait_q    <= wait_d;
      gap_q     <= gap_d;
      open_q    <= open_d;
      openRow_q <= openRow_d;
      bankPre_q <= bankPre_d;
    end
  end

  // Low-phase copies so strobes assert half a clock late
  always_ff @(negedge clock or negedge nrst) begin
    if (!nrst) begin
      rasLow_q  <= 1'b0;
      casLow_q  <= 1'b0;
      casTagN_q <= 1'b0;
    end else if (clockEn) begin
      rasLow_q  <= rasReq_q;
      casLow_q  <= casReq_q;
      casTagN_q <= casTag_q;
    end
  end

  // Strobes drop on the falling edge, rise on the rising edge
  always_comb begin
    rasOn = rasReq_q && rasLow_q;
    casOn = casReq_q && casLow_q && (casTagN_q == casTag_q);
    rowStrobeN = ~({cur_q.bank, ~cur_q.bank} & {2{rasOn}});
    colStrobeN = ~(lanes & {4{casOn}});
  end

  // Outputs
  assign internalTransferAck = ack_q;
  assign rdData   = rdData_q;
  assign rdValid  = rdValid_q;
  assign busOut   = bus_q;
  assign dataOut  = dOut_q;
  assign dataOe   = dOe_q;
  assign pageOpen = open_q;

endmodule

//--- dv/dnfps_core_props.sv
`timescale 1ns/1ps
module dnfps_core_props (
  input wire logic                  clock,
  input wire logic                  nrst,
  input wire dnfps_pkg::dnfps_req_s req,
  input wire logic                  reqValid,
  input wire logic                  reqReady,
  input wire dnfps_pkg::dnfps_cfg_s cfg,
  input wire logic                  refreshPending,
  input wire logic                  busMasterLost,
  input wire logic                  internalTransferAck,
  input wire logic [31:0]           rdData,
  input wire logic                  rdValid,
  input wire dnfps_pkg::dnfps_bus_s busOut,
  input wire logic [1:0]            rowStrobeN,
  input wire logic [3:0]            colStrobeN,
  input wire logic [31:0]           dataIn,
  input wire logic                  pageOpen
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Accepted request, and one that opens a row
  wire take = reqValid && reqReady;
  wire rowPath = take && !pageOpen;
  wire ack = internalTransferAck;

  property p_ts;
    take |=> !busOut.transferStartN ##1 busOut.transferStartN;
  endproperty
  a_ts: assert property (p_ts) else $error("start not one cycle");
  property p_row;
    rowPath |=> busOut.addr == $past(req.addr[27:9]) && rowStrobeN != 2'h3;
  endproperty
  a_row: assert property (p_row) else $error("row phase wrong");
  property p_col;
    rowPath |=> colStrobeN == 4'hf ##1 colStrobeN != 4'hf;
  endproperty
  a_col: assert property (p_col) else $error("column strobe late");
  property p_ack;
    rowPath && cfg.casExtra == 4'h0 |=> !ack ##1 !ack ##1 ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_rd;
    ack && busOut.dramRwIndicatorN && cfg.portSize == 2'h0
      |=> rdValid && rdData == $past(dataIn);
  endproperty
  a_rd: assert property (p_rd) else $error("read capture");
  property p_gap;
    ack |-> !reqReady ##1 !reqReady;
  endproperty
  a_gap: assert property (p_gap) else $error("start too early");
  property p_width;
    take |=> busOut.xferWidthCode == $past(req.width)
      && busOut.dramRwIndicatorN == $past(req.read);
  endproperty
  a_width: assert property (p_width) else $error("width or dir");
  property p_pulse;
    ack |=> !ack;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_close;
    (refreshPending || busMasterLost) && pageOpen |-> ##[1:16] !pageOpen;
  endproperty
  a_close: assert property (p_close) else $error("page kept open");
endmodule

bind dnfps_core dnfps_core_props u_props (.clock(clock), .nrst(nrst),
  .req(req), .reqValid(reqValid), .reqReady(reqReady), .cfg(cfg),
  .refreshPending(refreshPending), .busMasterLost(busMasterLost),
  .internalTransferAck(internalTransferAck), .rdData(rdData),
  .rdValid(rdValid), .busOut(busOut), .rowStrobeN(rowStrobeN),
  .colStrobeN(colStrobeN), .dataIn(dataIn), .pageOpen(pageOpen));

//--- dv/dnfps_dram_model.sv
`timescale 1ns/1ps
module dnfps_dram_model (
  input  wire logic [3:0]            colStrobeN,
  input  wire dnfps_pkg::dnfps_bus_s busOut,
  input  wire logic [31:0]           dataOut,
  input  wire logic                  dataOe,
  output logic [31:0]                dataIn
);
  logic        casLate;
  logic [31:0] held = '0;
  logic [31:0] lastWr = '0;
  int          nWr = 0;

  // Output hold time after the column strobe rises
  assign #20 casLate = colStrobeN[0];
  // Column capture: read pattern or write sample
  always @(negedge colStrobeN[0]) begin
    if (busOut.dramRwIndicatorN) begin
      held = {busOut.addr[15:0], ~busOut.addr[15:0]};
    end else begin
      lastWr = dataOe ? dataOut : ~dataOut;
      nWr++;
    end
  end
  // Drive while strobed, inverse pattern once released
  assign dataIn = (!casLate && busOut.dramRwIndicatorN) ? held : ~held;
endmodule

//--- dv/dnfps_core_tb_top.sv
`timescale 1ns/1ps
module dnfps_core_tb_top;
  logic                  clock = 1'b0;
  logic                  nrst = 1'b0;
  dnfps_pkg::dnfps_req_s req = '0;
  logic                  reqValid = 1'b0;
  logic [31:0]           wrData = '0;
  dnfps_pkg::dnfps_cfg_s cfg = '0;
  logic                  refreshPending = 1'b0;
  logic                  busMasterLost = 1'b0;
  logic                  reqReady, internalTransferAck, rdValid;
  logic                  dataOe, pageOpen, rowHigh;
  logic [31:0]           rdData, dataIn, dataOut;
  dnfps_pkg::dnfps_bus_s busOut;
  logic [1:0]            rowStrobeN;
  logic [3:0]            colStrobeN;
  logic [18:0]           tsAddr;
  int                    mismatches = 0;
  int                    comparisons = 0;
  int                    nAck, nTs, first, gap;
  time                   tTake;

  // Clock
  always #50 clock = ~clock;

  dnfps_core u_dnfps_core (.clock(clock), .clockEn(1'b1), .nrst(nrst),
    .req(req), .reqValid(reqValid), .reqReady(reqReady), .wrData(wrData),
    .cfg(cfg), .refreshPending(refreshPending),
    .busMasterLost(busMasterLost), .internalTransferAck(internalTransferAck),
    .rdData(rdData), .rdValid(rdValid), .busOut(busOut),
    .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe), .pageOpen(pageOpen));
  dnfps_dram_model u_dnfps_dram_model (.colStrobeN(colStrobeN),
    .busOut(busOut), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn));

  task automatic chk(input string n, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One request, then watch its beats
  task automatic xfer(input logic [31:0] a, input logic rd,
                      input logic [1:0] w, input int nb,
                      input logic [31:0] w1);
    int c, prev;
    logic ok;
    req = {a, rd, w, 1'b0};
    reqValid = 1'b1;
    for (c = 0; c < 40; c++) begin
      #70 ok = reqReady;
      @(posedge clock) #10;
      if (ok) break;
    end
    chk("taken", ok, 1);
    tTake = $time;
    reqValid = 1'b0;
    nAck = 0;
    nTs = 0;
    first = -1;
    rowHigh = 1'b0;
    prev = 0;
    for (c = 0; c < 40 && nAck < nb; c++) begin
      if (!busOut.transferStartN) begin
        nTs++;
        tsAddr = busOut.addr;
      end
      if (rowStrobeN[0]) rowHigh = 1'b1;
      if (internalTransferAck) begin
        if (nAck == 0) first = c;
        gap = c - prev;
        prev = c;
        nAck++;
        wrData = w1;
      end
      @(posedge clock) #10;
    end
  endtask

  // Page close by refresh or lost mastership
  task automatic close_page(input logic viaBus);
    int c;
    if (viaBus) busMasterLost = 1'b1;
    else refreshPending = 1'b1;
    for (c = 0; c < 20 && pageOpen; c++) @(posedge clock) #10;
    chk("closed", pageOpen, 0);
    busMasterLost = 1'b0;
    refreshPending = 1'b0;
  endtask

  // Back-to-back single reads, 32-bit port
  task automatic t_normal;
    time t0;
    cfg = {1'b0, dnfps_pkg::PORT_32, 2'h0, 8'h00};
    xfer(32'h0123_4560, 1'b1, dnfps_pkg::WIDTH_LONG, 1, '0);
    t0 = tTake;
    chk("ack cycle", first, 2);
    chk("rd data", rdData, {16'hd158, ~16'hd158});
    chk("rd valid", rdValid, 1);
    xfer(32'h0123_4564, 1'b1, dnfps_pkg::WIDTH_LONG, 1, '0);
    chk("spacing", 32'((tTake - t0) / 100), 5);
    $display("t_normal done");
  endtask

  // Longword write burst, 16-bit port
  task automatic t_write;
    cfg = {1'b0, dnfps_pkg::PORT_16, 2'h0, 8'h00};
    wrData = 32'h1234_0000;
    xfer(32'h0040_0800, 1'b0, dnfps_pkg::WIDTH_LONG, 2, 32'h5678_0000);
    chk("acks", nAck, 2);
    chk("starts", nTs, 1);
    chk("beat gap", gap, 4);
    chk("wr lanes", u_dnfps_dram_model.lastWr[31:16], 16'h5678);
    chk("wr beats", u_dnfps_dram_model.nWr, 2);
    chk("released", dataOe, 0);
    $display("t_write done");
  endtask

  // Fast page word burst, then page classification for page sizes 0 to 2
  task automatic t_pages;
    int b;
    logic [31:0] h, m;
    cfg = {1'b1, dnfps_pkg::PORT_8, 2'h0, 8'h00};
    xfer(32'h0012_3400, 1'b1, dnfps_pkg::WIDTH_WORD, 2, '0);
    chk("fp gap", gap, 2);
    chk("fp acks", nAck, 2);
    chk("open", pageOpen, 1);
    close_page(1'b0);
    for (b = 0; b < 3; b++) begin
      cfg.bankPageSize = b[1:0];
      xfer(32'h0012_3400, 1'b1, dnfps_pkg::WIDTH_BYTE, 1, '0);
      h = 32'h0012_3400 ^ (32'h1 << (8 + b));
      xfer(h, 1'b1, dnfps_pkg::WIDTH_BYTE, 1, '0);
      chk("hit addr", tsAddr, h[18:0]);
      chk("hit row", rowHigh, 0);
      chk("hit ack", first, 1);
      m = 32'h0012_3400 ^ (32'h1 << (9 + b));
      xfer(m, 1'b1, dnfps_pkg::WIDTH_BYTE, 1, '0);
      chk("miss addr", tsAddr, m[27:9]);
      chk("miss row", rowHigh, 1);
      close_page(b == 1);
    end
    $display("t_pages done");
  endtask

  initial begin
    repeat (5) @(posedge clock);
    #10 nrst = 1'b1;
    t_normal;
    t_write;
    t_pages;
    give_verdict;
  end

  // Watchdog at 10000 cycles, far beyond the hundred or so cycles the tests need
  initial begin
    #1_000_000;
    mismatches++;
    give_verdict;
  end
endmodule
